/* File: src/osc_trim_wake_pll_limit.sv */
// Oscillator trim selection, partial wake-up control and PLL multiplier ceiling.
// Assumes a single-cycle register port and peripherals that report activity and wake events.
//
// Overview of operation
// - Writes to trim, wake and ceiling registers ignored while protection is on.
// - Low trim uses user field when selected, else factory value.
// - Mid trim uses user field when selected, else factory value.
// - High trim uses user field when selected, else factory value.
// - Writing 1 to wake enable set arms wake-up; 0 leaves it alone.
// - Writing 1 to wake enable clear disarms wake-up; 0 does nothing.
// - Only two async serial ports and first two-wire port can wake.
// - Wake state reads 1 where wake-up is armed.
// - A detected wake condition clears that peripheral's wake state bit, unless a wake enable set write sets it in the same cycle.
// - Activity state reads 1 while a wake-capable peripheral is busy.
// - Activity bits of peripherals without wake-up always read 0.
// - Multiplier above ceiling is saturated to the ceiling.
// - Ceiling write cancelled while the multiplier is being saturated.
// - Ceiling write cancelled if new ceiling is below the multiplier.
// - Protection bit changes only with the correct 24-bit key.
//
// Chosen here: the plain strobed port.
`include "osc_wake_defines.svh"
`timescale 1ns/10ps
module osc_trim_wake_pll_limit #(
  parameter int MULT_WIDTH = `CEIL_WIDTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [31:0] address,
  input wire logic [31:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output osc_wake_pkg::word_t read_data,
  // Oscillator trim
  input wire osc_wake_pkg::trim_t factory_trim_low,
  input wire osc_wake_pkg::trim_t factory_trim_mid,
  input wire osc_wake_pkg::trim_t factory_trim_high,
  output osc_wake_pkg::trim_t trim_low_freq_applied,
  output osc_wake_pkg::trim_t trim_mid_freq_applied,
  output osc_wake_pkg::trim_t trim_high_freq_applied,
  // Peripheral wake-up
  input wire logic [31:0] peripheral_active,
  input wire logic [31:0] wake_detected,
  output logic [31:0] wake_armed,
  // PLL multiplier and write protection
  input wire logic [MULT_WIDTH-1:0] pll_multiplier,
  output logic [MULT_WIDTH-1:0] pll_multiplier_applied,
  output logic pll_mult_saturated,
  output logic write_protect_on
);

  //////////////////////////////////////////////////////////////////////////////
  // Decode

  localparam logic [31:0] WAKE_CAPABLE = (32'h00000001 << `ID_ASYNC_FIRST)
    | (32'h00000001 << `ID_ASYNC_SECOND) | (32'h00000001 << `ID_TWO_WIRE_FIRST);

  logic [31:0] rc_trim_select;
  logic [MULT_WIDTH-1:0] pll_mult_ceiling;
  logic wr_trim;
  logic wr_set;
  logic wr_clear;
  logic wr_ceiling;
  logic wr_protect;
  logic [MULT_WIDTH-1:0] new_ceiling;
  logic [31:0] next_wake;
  logic [31:0] activity;
  logic [31:0] next_read_data;
  logic key_match;
  logic ceiling_cancel;

  always_comb begin
    wr_protect = write_strobe && address == `ADDR_WRITE_PROTECT_MODE;
    // Protected registers drop writes silently while protection is on
    wr_trim = write_strobe && !write_protect_on
      && address == `ADDR_RC_TRIM_SELECT;
    wr_set = write_strobe && !write_protect_on
      && address == `ADDR_WAKE_ENABLE_SET;
    wr_clear = write_strobe && !write_protect_on
      && address == `ADDR_WAKE_ENABLE_CLEAR;
    wr_ceiling = write_strobe && !write_protect_on
      && address == `ADDR_PLL_MULTIPLIER_CEILING;
    new_ceiling = write_data[MULT_WIDTH-1:0];
    key_match = write_data[31:8] == `WP_KEY;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write protection

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      write_protect_on <= 1'b0;
    end else if (wr_protect && key_match) begin
      write_protect_on <= write_data[0];
    end
  end

  // Only a keyed write may move the protection bit
  key_guard_a: assert property (@(posedge clock) disable iff (reset)
    (wr_protect && write_data[31:8] != `WP_KEY) |=> $stable(write_protect_on))
    else $error("protection changed without key");
  key_take_a: assert property (@(posedge clock) disable iff (reset)
    (wr_protect && write_data[31:8] == `WP_KEY) |=> write_protect_on == $past(write_data[0]))
    else $error("keyed protection write lost");
  protect_blocks_a: assert property (@(posedge clock) disable iff (reset)
    (write_protect_on && write_strobe) |=> $stable(rc_trim_select) && $stable(pll_mult_ceiling))
    else $error("protected register changed");
  protect_wake_a: assert property (@(posedge clock) disable iff (reset)
    (write_protect_on && write_strobe && wake_detected == 32'h00000000) |=> $stable(wake_armed))
    else $error("protected wake state changed");

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator trim

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rc_trim_select <= `TRIM_RESET;
    end else if (wr_trim) begin
      rc_trim_select <= {8'h00, write_data[23:0]};
    end
  end

  trim_select u_trim_low (
    .use_user(rc_trim_select[`TRIM_LOW_LSB + `TRIM_SEL_OFS]),
    .user_trim(rc_trim_select[`TRIM_LOW_LSB +: 7]),
    .factory_trim(factory_trim_low),
    .applied(trim_low_freq_applied)
  );

  trim_select u_trim_mid (
    .use_user(rc_trim_select[`TRIM_MID_LSB + `TRIM_SEL_OFS]),
    .user_trim(rc_trim_select[`TRIM_MID_LSB +: 7]),
    .factory_trim(factory_trim_mid),
    .applied(trim_mid_freq_applied)
  );

  trim_select u_trim_high (
    .use_user(rc_trim_select[`TRIM_HIGH_LSB + `TRIM_SEL_OFS]),
    .user_trim(rc_trim_select[`TRIM_HIGH_LSB +: 7]),
    .factory_trim(factory_trim_high),
    .applied(trim_high_freq_applied)
  );

  // Each applied trim follows its own select bit and nothing else
  trim_low_a: assert property (@(posedge clock) disable iff (reset)
    trim_low_freq_applied == (rc_trim_select[7] ? rc_trim_select[6:0] : factory_trim_low))
    else $error("low trim wrong");
  trim_mid_a: assert property (@(posedge clock) disable iff (reset)
    trim_mid_freq_applied == (rc_trim_select[15] ? rc_trim_select[14:8] : factory_trim_mid))
    else $error("mid trim wrong");
  trim_high_a: assert property (@(posedge clock) disable iff (reset)
    trim_high_freq_applied == (rc_trim_select[23] ? rc_trim_select[22:16] : factory_trim_high))
    else $error("high trim wrong");
  trim_top_a: assert property (@(posedge clock) disable iff (reset)
    rc_trim_select[31:24] == 8'h00)
    else $error("reserved trim bits set");
  trim_write_a: assert property (@(posedge clock) disable iff (reset)
    wr_trim |=> rc_trim_select == {8'h00, $past(write_data[23:0])})
    else $error("trim write not stored");

  //////////////////////////////////////////////////////////////////////////////
  // Partial wake-up

  // Only one strobe per cycle, so the write seen this cycle is the later one
  always_comb begin
    next_wake = wake_armed;
    next_wake = next_wake & ~wake_detected;
    if (wr_set) begin
      next_wake = next_wake | write_data;
    end
    if (wr_clear) begin
      next_wake = next_wake & ~write_data;
    end
    next_wake = next_wake & WAKE_CAPABLE & `WAKE_MASK;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wake_armed <= 32'h00000000;
    end else begin
      wake_armed <= next_wake;
    end
  end

  assign activity = peripheral_active & WAKE_CAPABLE;

  // Written ones act, written zeros leave every other bit as it was
  wake_set_a: assert property (@(posedge clock) disable iff (reset)
    (wr_set && write_data[`ID_ASYNC_FIRST] && !wake_detected[`ID_ASYNC_FIRST])
    |=> wake_armed[`ID_ASYNC_FIRST])
    else $error("wake enable lost");
  wake_keep_a: assert property (@(posedge clock) disable iff (reset)
    (wr_set && wake_detected == 32'h00000000)
    |=> (wake_armed & ~$past(write_data)) == ($past(wake_armed) & ~$past(write_data)))
    else $error("wake enable touched a zero bit");
  wake_clear_a: assert property (@(posedge clock) disable iff (reset)
    wr_clear |=> (wake_armed & $past(write_data)) == 32'h00000000)
    else $error("wake disable lost");
  clear_keep_a: assert property (@(posedge clock) disable iff (reset)
    (wr_clear && wake_detected == 32'h00000000)
    |=> (wake_armed | $past(write_data)) == ($past(wake_armed) | $past(write_data)))
    else $error("wake disable touched a zero bit");
  wake_capable_a: assert property (@(posedge clock) disable iff (reset)
    (wake_armed & ~WAKE_CAPABLE) == 32'h00000000)
    else $error("wake bit on incapable peripheral");
  wake_reserved_a: assert property (@(posedge clock) disable iff (reset)
    (wake_armed & ~`WAKE_MASK) == 32'h00000000)
    else $error("reserved wake bit set");
  wake_event_a: assert property (@(posedge clock) disable iff (reset)
    (wake_detected != 32'h00000000 && !wr_set)
    |=> (wake_armed & $past(wake_detected)) == 32'h00000000)
    else $error("wake event did not clear");

  //////////////////////////////////////////////////////////////////////////////
  // PLL multiplier ceiling

  assign pll_mult_saturated = pll_multiplier > pll_mult_ceiling;
  assign pll_multiplier_applied = pll_mult_saturated ? pll_mult_ceiling
    : pll_multiplier;
  // Either case keeps the old ceiling; a lower one would cut a running multiplier
  assign ceiling_cancel = pll_mult_saturated
    || (new_ceiling < pll_multiplier);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pll_mult_ceiling <= MULT_WIDTH'(`CEIL_RESET);
    end else if (wr_ceiling && !ceiling_cancel) begin
      pll_mult_ceiling <= new_ceiling;
    end
  end

  saturate_out_a: assert property (@(posedge clock) disable iff (reset)
    pll_multiplier_applied <= pll_mult_ceiling)
    else $error("multiplier above ceiling");
  saturate_pass_a: assert property (@(posedge clock) disable iff (reset)
    (pll_multiplier <= pll_mult_ceiling) |-> pll_multiplier_applied == pll_multiplier)
    else $error("multiplier altered below ceiling");
  ceiling_cancel_a: assert property (@(posedge clock) disable iff (reset)
    (wr_ceiling && new_ceiling < pll_multiplier) |=> $stable(pll_mult_ceiling))
    else $error("ceiling write not cancelled");
  sat_cancel_a: assert property (@(posedge clock) disable iff (reset)
    (wr_ceiling && pll_multiplier > pll_mult_ceiling) |=> $stable(pll_mult_ceiling))
    else $error("ceiling moved while saturating");
  ceiling_take_a: assert property (@(posedge clock) disable iff (reset)
    (wr_ceiling && pll_multiplier <= pll_mult_ceiling && new_ceiling >= pll_multiplier)
    |=> pll_mult_ceiling == $past(new_ceiling))
    else $error("legal ceiling write lost");

  //////////////////////////////////////////////////////////////////////////////
  // Read back

  always_comb begin
    next_read_data = 32'h00000000;
    if (read_strobe) begin
      unique case (address)
        `ADDR_RC_TRIM_SELECT: next_read_data = rc_trim_select;
        `ADDR_WAKE_ENABLE_STATE: next_read_data = wake_armed;
        `ADDR_PERIPHERAL_ACTIVITY_STATE: next_read_data = activity;
        `ADDR_PLL_MULTIPLIER_CEILING:
          next_read_data = {{(32-MULT_WIDTH){1'b0}}, pll_mult_ceiling};
        // Key field always reads zero
        `ADDR_WRITE_PROTECT_MODE: next_read_data = {31'h00000000, write_protect_on};
        default: next_read_data = 32'h00000000;
      endcase
    end
  end

  // Zero outside the answer cycle, so a late sample never sees stale data
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      read_data <= 32'h00000000;
    end else begin
      read_data <= next_read_data;
    end
  end

  read_zero_a: assert property (@(posedge clock) disable iff (reset)
    (read_strobe && address == `ADDR_WAKE_ENABLE_SET) |=> read_data == 32'h00000000)
    else $error("write-only register read nonzero");
  read_state_a: assert property (@(posedge clock) disable iff (reset)
    (read_strobe && address == `ADDR_WAKE_ENABLE_STATE) |=> read_data == $past(wake_armed))
    else $error("wake state read wrong");
  read_activity_a: assert property (@(posedge clock) disable iff (reset)
    (read_strobe && address == `ADDR_PERIPHERAL_ACTIVITY_STATE)
    |=> read_data == ($past(peripheral_active) & WAKE_CAPABLE))
    else $error("activity read wrong");
  activity_zero_a: assert property (@(posedge clock) disable iff (reset)
    (read_strobe && address == `ADDR_PERIPHERAL_ACTIVITY_STATE)
    |=> (read_data & ~WAKE_CAPABLE) == 32'h00000000)
    else $error("activity bit on incapable peripheral");
  trim_read_a: assert property (@(posedge clock) disable iff (reset)
    (read_strobe && address == `ADDR_RC_TRIM_SELECT) |=> read_data == $past(rc_trim_select))
    else $error("trim read wrong");
  protect_read_a: assert property (@(posedge clock) disable iff (reset)
    (read_strobe && address == `ADDR_WRITE_PROTECT_MODE)
    |=> read_data == {31'h00000000, $past(write_protect_on)})
    else $error("protection read wrong");

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  // Main scenarios that the bench is expected to reach
  arm_cover: cover property (@(posedge clock) disable iff (reset) wr_set ##1 wake_armed != 0);
  wake_cover: cover property (@(posedge clock) disable iff (reset)
    (wake_armed != 0) ##1 (wake_armed == 0));
  sat_cover: cover property (@(posedge clock) disable iff (reset) pll_mult_saturated);
  cancel_cover: cover property (@(posedge clock) disable iff (reset)
    wr_ceiling && ceiling_cancel);
  lock_cover: cover property (@(posedge clock) disable iff (reset)
    write_protect_on && write_strobe);

endmodule

/* File: src/osc_wake_defines.svh */
// Constants for the trim, wake and multiplier ceiling register block.
// Assumes byte addresses on a 32-bit register port.
`ifndef OSC_WAKE_DEFINES_SVH
`define OSC_WAKE_DEFINES_SVH

`define ADDR_RC_TRIM_SELECT 32'h400E0510
`define ADDR_WAKE_ENABLE_SET 32'h400E0514
`define ADDR_WAKE_ENABLE_CLEAR 32'h400E0518
`define ADDR_WAKE_ENABLE_STATE 32'h400E051C
`define ADDR_PERIPHERAL_ACTIVITY_STATE 32'h400E0520
`define ADDR_PLL_MULTIPLIER_CEILING 32'h400E0530
`define ADDR_WRITE_PROTECT_MODE 32'h400E04E4

`define TRIM_LOW_LSB 0
`define TRIM_MID_LSB 8
`define TRIM_HIGH_LSB 16
`define TRIM_SEL_OFS 7
`define TRIM_RESET 32'h00000000
`define WAKE_MASK 32'h3FFFFF00
`define CEIL_WIDTH 11
`define CEIL_RESET 11'h7FF
`define WP_KEY 24'h504D43
`define ID_ASYNC_FIRST 8
`define ID_ASYNC_SECOND 9
`define ID_TWO_WIRE_FIRST 10

`endif

/* File: src/osc_wake_pkg.sv */
// Types shared by the trim, wake and multiplier ceiling block.
// Assumes nothing beyond a SystemVerilog compiler.
package osc_wake_pkg;
  typedef logic [6:0] trim_t;
  typedef logic [31:0] word_t;
endpackage

/* File: src/trim_select.sv */
// One trim selector: user field or factory value.
// Assumes the factory value is a stable input.
`timescale 1ns/10ps
module trim_select (
  // Choice
  input wire logic use_user,
  input wire osc_wake_pkg::trim_t user_trim,
  input wire osc_wake_pkg::trim_t factory_trim,
  // Result
  output osc_wake_pkg::trim_t applied
);
  assign applied = use_user ? user_trim : factory_trim;
endmodule

/* File: sim/test_osc_trim_wake_pll_limit.sv */
// Self-checking bench for the trim, wake and multiplier ceiling register block.
// Assumes read data stand only in the cycle after the read strobe.
`include "osc_wake_defines.svh"
`timescale 1ns/10ps
module test_osc_trim_wake_pll_limit;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [31:0] address = 32'h0;
  logic [31:0] write_data = 32'h0;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic [31:0] peripheral_active = 32'h0;
  logic [31:0] wake_detected = 32'h0;
  logic [10:0] pll_multiplier = 11'h0;
  osc_wake_pkg::word_t read_data;
  osc_wake_pkg::trim_t trim_low;
  osc_wake_pkg::trim_t trim_mid;
  osc_wake_pkg::trim_t trim_high;
  logic [31:0] wake_armed;
  logic [10:0] mult_applied;
  logic saturated;
  logic protect;
  logic [31:0] seen;
  int bad_count = 0;
  int samples_checked = 0;

  osc_trim_wake_pll_limit uut (.clock(clock), .reset(reset), .address(address),
    .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .factory_trim_low(7'h11), .factory_trim_mid(7'h22),
    .factory_trim_high(7'h44), .trim_low_freq_applied(trim_low),
    .trim_mid_freq_applied(trim_mid), .trim_high_freq_applied(trim_high),
    .peripheral_active(peripheral_active), .wake_detected(wake_detected),
    .wake_armed(wake_armed), .pll_multiplier(pll_multiplier),
    .pll_multiplier_applied(mult_applied), .pll_mult_saturated(saturated),
    .write_protect_on(protect));

  always #4 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
    #1;
  endtask

  // Read data are caught in the single cycle they stand
  task automatic rd(input logic [31:0] a);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1;
    seen = read_data;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic trim_choice;
    rd(`ADDR_RC_TRIM_SELECT);
    check("trim reset", seen, 32'h0);
    wr(`ADDR_RC_TRIM_SELECT, 32'hFFB30A85);
    check("low user", trim_low, 7'h05);
    check("mid factory", trim_mid, 7'h22);
    check("high user", trim_high, 7'h33);
    rd(`ADDR_RC_TRIM_SELECT);
    check("trim readback", seen, 32'h00B30A85);
    wr(`ADDR_RC_TRIM_SELECT, 32'h00338A05);
    check("low factory", trim_low, 7'h11);
    check("mid user", trim_mid, 7'h0A);
    check("high factory", trim_high, 7'h44);
  endtask

  task automatic wake_control;
    peripheral_active <= 32'hFFFFFFFF;
    rd(`ADDR_PERIPHERAL_ACTIVITY_STATE);
    check("activity busy", seen, 32'h00000700);
    // Peripherals idle, their clocks taken as running, before wake-up is armed
    peripheral_active <= 32'h0;
    rd(`ADDR_PERIPHERAL_ACTIVITY_STATE);
    check("activity idle", seen, 32'h0);
    wr(`ADDR_WAKE_ENABLE_SET, 32'hFFFFFFFF);
    check("arm all", wake_armed, 32'h00000700);
    rd(`ADDR_WAKE_ENABLE_STATE);
    check("state read", seen, 32'h00000700);
    wr(`ADDR_WAKE_ENABLE_SET, 32'h0);
    check("set zero", wake_armed, 32'h00000700);
    wr(`ADDR_WAKE_ENABLE_CLEAR, 32'h00000200);
    check("disarm one", wake_armed, 32'h00000500);
    wr(`ADDR_WAKE_ENABLE_CLEAR, 32'h0);
    check("clear zero", wake_armed, 32'h00000500);
    @(posedge clock);
    wake_detected <= 32'h00000100;
    @(posedge clock);
    wake_detected <= 32'h0;
    #1;
    rd(`ADDR_WAKE_ENABLE_STATE);
    check("wake clears", seen, 32'h00000400);
  endtask

  task automatic ceiling;
    rd(`ADDR_PLL_MULTIPLIER_CEILING);
    check("ceil reset", seen, 32'h000007FF);
    pll_multiplier <= 11'h100;
    wr(`ADDR_PLL_MULTIPLIER_CEILING, 32'h00000080);
    rd(`ADDR_PLL_MULTIPLIER_CEILING);
    check("ceil below mult", seen, 32'h000007FF);
    wr(`ADDR_PLL_MULTIPLIER_CEILING, 32'h00000200);
    pll_multiplier <= 11'h300;
    rd(`ADDR_PLL_MULTIPLIER_CEILING);
    check("ceil taken", seen, 32'h00000200);
    check("saturate value", mult_applied, 11'h200);
    check("saturate flag", saturated, 1'b1);
    wr(`ADDR_PLL_MULTIPLIER_CEILING, 32'h00000400);
    rd(`ADDR_PLL_MULTIPLIER_CEILING);
    check("ceil while sat", seen, 32'h00000200);
    pll_multiplier <= 11'h150;
    @(posedge clock);
    #1;
    check("pass value", mult_applied, 11'h150);
    check("pass flag", saturated, 1'b0);
  endtask

  task automatic protection;
    wr(`ADDR_WRITE_PROTECT_MODE, 32'h12345601);
    check("bad key", protect, 1'b0);
    wr(`ADDR_WRITE_PROTECT_MODE, {`WP_KEY, 8'h01});
    check("good key", protect, 1'b1);
    rd(`ADDR_WRITE_PROTECT_MODE);
    check("protect read", seen, 32'h1);
    wr(`ADDR_RC_TRIM_SELECT, 32'h0);
    wr(`ADDR_WAKE_ENABLE_SET, 32'h00000100);
    wr(`ADDR_WAKE_ENABLE_CLEAR, 32'h00000400);
    wr(`ADDR_PLL_MULTIPLIER_CEILING, 32'h000007FF);
    rd(`ADDR_RC_TRIM_SELECT);
    check("locked trim", seen, 32'h00338A05);
    check("locked wake", wake_armed, 32'h00000400);
    rd(`ADDR_PLL_MULTIPLIER_CEILING);
    check("locked ceil", seen, 32'h00000200);
    wr(`ADDR_WRITE_PROTECT_MODE, {`WP_KEY, 8'h00});
    check("unlock", protect, 1'b0);
    rd(32'h400E05F0);
    check("unmapped", seen, 32'h0);
    rd(`ADDR_WAKE_ENABLE_SET);
    check("write-only read", seen, 32'h0);
  endtask

  // Reset in mid-run must drop protection, wake state, trim choice and ceiling
  task automatic reset_mid;
    wr(`ADDR_WRITE_PROTECT_MODE, {`WP_KEY, 8'h01});
    check("relock", protect, 1'b1);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    #1;
    check("reset protect", protect, 1'b0);
    check("reset wake", wake_armed, 32'h0);
    check("reset trim", trim_mid, 7'h22);
    rd(`ADDR_PLL_MULTIPLIER_CEILING);
    check("reset ceil", seen, 32'h000007FF);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    trim_choice();
    wake_control();
    ceiling();
    protection();
    reset_mid();
    summarize();
  end

  // Whole run is under a hundred cycles; this limit of 12500 cycles is far beyond it
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
endmodule
